/* rtl/rtcfs_params.svh */
// Constants for the clock flags and control block: map, bit fields, resets and timing
`ifndef RTCFS_PARAMS_SVH
`define RTCFS_PARAMS_SVH

// Register port widths
`define RTCFS_ADDR_W 4
`define RTCFS_DATA_W 8

// Register offsets
`define RTCFS_ADDR_FLAGS 4'h0
`define RTCFS_ADDR_IRQ_STAT 4'h1
`define RTCFS_ADDR_IRQ_MASK 4'h2

// Flags byte bit positions
`define RTCFS_BIT_WDF 7
`define RTCFS_BIT_AF 6
`define RTCFS_BIT_PF 5
`define RTCFS_BIT_OSCILLATOR_FAIL_FLAG 4
`define RTCFS_BIT_CAL 2
`define RTCFS_BIT_W 1
`define RTCFS_BIT_R 0

// Interrupt status and mask bit positions
`define RTCFS_EVENTS 4
`define RTCFS_EV_WDOG 3
`define RTCFS_EV_ALARM 2
`define RTCFS_EV_PFAIL 1
`define RTCFS_EV_OSCILLATOR_FAIL_FLAG 0

// Reset values
`define RTCFS_IRQ_STAT_RST 4'h0
`define RTCFS_IRQ_MASK_RST 4'h0
`define RTCFS_RD_DATA_RST 8'h00

// Alarm comparison: seconds, minutes, hours, date
`define RTCFS_ALARM_FIELDS 4

// Timing
`define RTCFS_CLK_HZ 100000000
`define RTCFS_OSC_START_MS 5
`define RTCFS_OSC_START_CYC ((`RTCFS_OSC_START_MS * `RTCFS_CLK_HZ + 999) / 1000)
`define RTCFS_CAL_HZ 512
`define RTCFS_CAL_HALF_CYC (`RTCFS_CLK_HZ / (2 * `RTCFS_CAL_HZ))

`endif

/* rtl/rtcfs_pkg.sv */
// Types shared by the clock flags and control block
`include "rtcfs_params.svh"
package rtcfs_pkg;

	// Register port request
	typedef struct packed {
		logic [`RTCFS_ADDR_W-1:0] addr;
		logic [`RTCFS_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} rtcfs_bus_type;

	// Flags byte layout
	typedef struct packed {
		logic watchdog_expired_flag;
		logic af;
		logic pf;
		logic oscillator_fail_flag;
		logic zero;
		logic cal;
		logic w;
		logic r;
	} rtcfs_flags_type;

	// Current time against alarm settings, BCD bytes
	typedef struct packed {
		logic [`RTCFS_ALARM_FIELDS-1:0][7:0] now;
		logic [`RTCFS_ALARM_FIELDS-1:0][7:0] alarm;
		logic [`RTCFS_ALARM_FIELDS-1:0] mask;
	} rtcfs_alarm_type;

	// Controls toward the timekeeping counters
	typedef struct packed {
		logic freeze;
		logic load_base;
		logic hold_update;
	} rtcfs_time_ctrl_type;

	// Oscillator start check
	typedef enum logic [0:0] {
		RTCFS_OSC_WAIT = 1'b0,
		RTCFS_OSC_DONE = 1'b1
	} rtcfs_osc_state_type;

endpackage

/* rtl/rtcfs_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rtcfs_sync #(
	parameter int W = 2
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// One pair of flops per bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					meta_q[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_q[i] <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule // rtcfs_sync

/* rtl/rtcfs_sqwave.sv */
// Calibration square-wave generator
`timescale 1ns/1ps
module rtcfs_sqwave #(
	parameter int HALF_CYC = 97656
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic enable,
	output logic wave_q
);
	logic [31:0] cnt_q;
	logic last_w;

	assign last_w = (cnt_q == 32'(HALF_CYC - 1));

	// Toggle each half period, parked low while disabled
	always_ff @(posedge clk_sys) begin
		if (!resetn || !enable) begin
			cnt_q <= 32'h0;
			wave_q <= 1'b0;
		end else if (last_w) begin
			cnt_q <= 32'h0;
			wave_q <= ~wave_q;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end
endmodule // rtcfs_sqwave

/* rtl/rtcfs_top.sv */
// Flags and control byte of the real-time clock, with interrupt status and mask
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "rtcfs_params.svh"

module rtcfs_top
	import rtcfs_pkg::*;
#(
	parameter int OSC_START_CYC = `RTCFS_OSC_START_CYC,
	parameter int CAL_HALF_CYC = `RTCFS_CAL_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic backup_resetn,
	input wire rtcfs_bus_type bus,
	output logic [`RTCFS_DATA_W-1:0] rd_data_q,
	input wire rtcfs_alarm_type alarm_in,
	input wire logic wdog_zero,
	input wire logic time_written,
	input wire logic osc_enabled,
	input wire logic power_fail_threshold,
	input wire logic osc_running_pin,
	output logic int_out_q,
	output rtcfs_time_ctrl_type time_ctrl_q
);

	// Pin inputs after synchronisation
	logic [1:0] pins_sync;
	logic below_sync;
	logic osc_run_sync;

	// Event edge detection
	logic wdog_zero_q;
	logic alarm_match_q;
	logic below_q;
	logic [`RTCFS_ALARM_FIELDS-1:0] field_ok;
	logic alarm_match;
	logic wdog_set;
	logic alarm_set;
	logic pfail_set;
	logic oscillator_fail_flag_set;

	// Register decode
	logic flags_sel;
	logic stat_sel;
	logic mask_sel;
	logic flags_rd;
	logic flags_wr;
	logic stat_rd;
	logic mask_wr;

	// Flags byte state
	logic watchdog_expired_flag_q;
	logic alarm_match_flag_q;
	logic power_fail_flag_q;
	logic oscillator_fail_flag_q;
	logic cal_q;
	logic cal_d;
	logic w_q;
	logic w_d;
	logic r_q;
	logic r_d;
	logic oscillator_fail_flag_clear;
	rtcfs_flags_type flags_view;

	// Oscillator start check
	rtcfs_osc_state_type osc_state_q;
	rtcfs_osc_state_type osc_state_d;
	logic [31:0] osc_cnt_q;
	logic osc_seen_q;
	logic osc_cnt_last;
	logic osc_deadline;

	// Base time reload
	logic time_dirty_q;
	logic w_release;
	logic load_base_d;

	// Interrupt status and mask
	logic [`RTCFS_EVENTS-1:0] irq_stat_q;
	logic [`RTCFS_EVENTS-1:0] irq_mask_q;
	logic [`RTCFS_EVENTS-1:0] irq_events;
	logic irq_level;
	logic cal_wave;

	// Read path
	logic [`RTCFS_DATA_W-1:0] rd_mux;

	// Supply comparator and oscillator status arrive from pins
	rtcfs_sync #(
		.W(2)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.async_in({power_fail_threshold, osc_running_pin}),
		.sync_out(pins_sync)
	);

	assign below_sync = pins_sync[1];
	assign osc_run_sync = pins_sync[0];

	// Field compare: a masked field always matches
	genvar f;
	generate
		for (f = 0; f < `RTCFS_ALARM_FIELDS; f++) begin : g_field
			assign field_ok[f] = alarm_in.mask[f] |
				(alarm_in.now[f] == alarm_in.alarm[f]);
		end
	endgenerate

	assign alarm_match = &field_ok;

	// Delayed copies for rising-edge detection
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wdog_zero_q <= 1'b0;
			alarm_match_q <= 1'b0;
			below_q <= 1'b0;
		end else begin
			wdog_zero_q <= wdog_zero;
			alarm_match_q <= alarm_match;
			below_q <= below_sync;
		end
	end

	// One event per new condition, so a read inside the same second sticks
	assign wdog_set = wdog_zero & ~wdog_zero_q;
	assign alarm_set = alarm_match & ~alarm_match_q;
	assign pfail_set = below_sync & ~below_q;

	// Address decode and strobes
	assign flags_sel = (bus.addr == `RTCFS_ADDR_FLAGS);
	assign stat_sel = (bus.addr == `RTCFS_ADDR_IRQ_STAT);
	assign mask_sel = (bus.addr == `RTCFS_ADDR_IRQ_MASK);
	assign flags_rd = bus.rd & flags_sel;
	assign flags_wr = bus.wr & flags_sel;
	assign stat_rd = bus.rd & stat_sel;
	assign mask_wr = bus.wr & mask_sel;

	// Watchdog flag: set wins over the read clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			watchdog_expired_flag_q <= 1'b0;
		end else if (wdog_set) begin
			watchdog_expired_flag_q <= 1'b1;
		end else if (flags_rd) begin
			watchdog_expired_flag_q <= 1'b0;
		end
	end

	// Alarm flag: set wins over the read clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			alarm_match_flag_q <= 1'b0;
		end else if (alarm_set) begin
			alarm_match_flag_q <= 1'b1;
		end else if (flags_rd) begin
			alarm_match_flag_q <= 1'b0;
		end
	end

	// Power fail flag: set wins over the read clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			power_fail_flag_q <= 1'b0;
		end else if (pfail_set) begin
			power_fail_flag_q <= 1'b1;
		end else if (flags_rd) begin
			power_fail_flag_q <= 1'b0;
		end
	end

	// Oscillator fail clears only by a zero written to its bit
	assign oscillator_fail_flag_clear = flags_wr & ~bus.wdata[`RTCFS_BIT_OSCILLATOR_FAIL_FLAG];

	// Retained across power-up; of the two resets only the backup-domain reset clears it
	always_ff @(posedge clk_sys) begin
		if (!backup_resetn) begin
			oscillator_fail_flag_q <= 1'b0;
		end else if (oscillator_fail_flag_set) begin
			oscillator_fail_flag_q <= 1'b1;
		end else if (oscillator_fail_flag_clear) begin
			oscillator_fail_flag_q <= 1'b0;
		end
	end

	// Control bits take the written byte
	assign cal_d = flags_wr ? bus.wdata[`RTCFS_BIT_CAL] : cal_q;
	assign w_d = flags_wr ? bus.wdata[`RTCFS_BIT_W] : w_q;
	assign r_d = flags_wr ? bus.wdata[`RTCFS_BIT_R] : r_q;

	// Control bits, all cleared at power-up
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cal_q <= 1'b0;
			w_q <= 1'b0;
			r_q <= 1'b0;
		end else begin
			cal_q <= cal_d;
			w_q <= w_d;
			r_q <= r_d;
		end
	end

	// Oscillator start window after power-up
	assign osc_cnt_last = (osc_cnt_q == 32'(OSC_START_CYC - 1));
	assign osc_deadline = (osc_state_q == RTCFS_OSC_WAIT) & osc_cnt_last;
	assign oscillator_fail_flag_set = osc_deadline & osc_enabled & ~osc_seen_q & ~osc_run_sync;

	// Check ends early once the oscillator is seen running
	always_comb begin
		osc_state_d = osc_state_q;
		unique case (osc_state_q)
			RTCFS_OSC_WAIT: begin
				if (osc_run_sync || osc_seen_q || osc_cnt_last) begin
					osc_state_d = RTCFS_OSC_DONE;
				end
			end
			RTCFS_OSC_DONE: begin
				osc_state_d = RTCFS_OSC_DONE;
			end
		endcase
	end

	// Window counter and running-seen memory
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			osc_state_q <= RTCFS_OSC_WAIT;
			osc_cnt_q <= 32'h0;
			osc_seen_q <= 1'b0;
		end else begin
			osc_state_q <= osc_state_d;
			if (osc_state_q == RTCFS_OSC_WAIT) begin
				osc_cnt_q <= osc_cnt_q + 32'h1;
			end
			if (osc_run_sync) begin
				osc_seen_q <= 1'b1;
			end
		end
	end

	// Hold released by a write that clears the bit
	assign w_release = w_q & ~w_d;
	assign load_base_d = w_release & (time_dirty_q | time_written);

	// Remember that time was changed under the hold
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			time_dirty_q <= 1'b0;
		end else if (load_base_d) begin
			time_dirty_q <= 1'b0;
		end else if (w_q && time_written) begin
			time_dirty_q <= 1'b1;
		end
	end

	// Controls toward the timekeeping counters
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			time_ctrl_q.freeze <= 1'b0;
			time_ctrl_q.load_base <= 1'b0;
			time_ctrl_q.hold_update <= 1'b1;
		end else begin
			time_ctrl_q.freeze <= w_d;
			time_ctrl_q.load_base <= load_base_d;
			time_ctrl_q.hold_update <= ~r_d;
		end
	end

	// Events mirrored into the interrupt status register
	assign irq_events[`RTCFS_EV_WDOG] = wdog_set;
	assign irq_events[`RTCFS_EV_ALARM] = alarm_set;
	assign irq_events[`RTCFS_EV_PFAIL] = pfail_set;
	assign irq_events[`RTCFS_EV_OSCILLATOR_FAIL_FLAG] = oscillator_fail_flag_set;

	// Sticky status per event; a set in the reading cycle survives
	genvar e;
	generate
		for (e = 0; e < `RTCFS_EVENTS; e++) begin : g_stat
			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					irq_stat_q[e] <= 1'b0;
				end else if (irq_events[e]) begin
					irq_stat_q[e] <= 1'b1;
				end else if (stat_rd) begin
					irq_stat_q[e] <= 1'b0;
				end
			end
		end
	endgenerate

	// Interrupt mask register
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			irq_mask_q <= `RTCFS_IRQ_MASK_RST;
		end else if (mask_wr) begin
			irq_mask_q <= bus.wdata[`RTCFS_EVENTS-1:0];
		end
	end

	assign irq_level = |(irq_stat_q & irq_mask_q);

	// Calibration wave runs only while its bit is set
	rtcfs_sqwave #(
		.HALF_CYC(CAL_HALF_CYC)
	) u_sqwave (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.enable(cal_q),
		.wave_q(cal_wave)
	);

	// Interrupt pin: square wave in calibration, else interrupt level
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			int_out_q <= 1'b0;
		end else begin
			int_out_q <= cal_q ? cal_wave : irq_level;
		end
	end

	// Flags byte as software sees it
	assign flags_view.watchdog_expired_flag = watchdog_expired_flag_q;
	assign flags_view.af = alarm_match_flag_q;
	assign flags_view.pf = power_fail_flag_q;
	assign flags_view.oscillator_fail_flag = oscillator_fail_flag_q;
	assign flags_view.zero = 1'b0;
	assign flags_view.cal = cal_q;
	assign flags_view.w = w_q;
	assign flags_view.r = r_q;

	// Read selection; unmapped addresses read zero
	assign rd_mux = flags_sel ? flags_view :
		stat_sel ? {4'h0, irq_stat_q} :
		mask_sel ? {4'h0, irq_mask_q} :
		`RTCFS_RD_DATA_RST;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rd_data_q <= `RTCFS_RD_DATA_RST;
		end else if (bus.rd) begin
			rd_data_q <= rd_mux;
		end else begin
			rd_data_q <= `RTCFS_RD_DATA_RST;
		end
	end

endmodule // rtcfs_top

/* dv/rtcfs_top_properties.sv */
// Port checker for the flags and control block
`timescale 1ns/1ps
`include "rtcfs_params.svh"
module rtcfs_top_properties
	import rtcfs_pkg::*;
#(
	parameter int OSC_START_CYC = 20,
	parameter int CAL_HALF_CYC = 4
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic backup_resetn,
	input wire rtcfs_bus_type bus,
	input wire logic [`RTCFS_DATA_W-1:0] rd_data_q,
	input wire rtcfs_alarm_type alarm_in,
	input wire logic wdog_zero,
	input wire logic time_written,
	input wire logic osc_enabled,
	input wire logic power_fail_threshold,
	input wire logic osc_running_pin,
	input wire logic int_out_q,
	input wire rtcfs_time_ctrl_type time_ctrl_q
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// Alarm match: every unmasked field equal
	wire flags_wr = bus.wr && bus.addr == `RTCFS_ADDR_FLAGS;
	wire [3:0] fld_eq = {alarm_in.now[3] == alarm_in.alarm[3],
		alarm_in.now[2] == alarm_in.alarm[2], alarm_in.now[1] == alarm_in.alarm[1],
		alarm_in.now[0] == alarm_in.alarm[0]};
	wire alarm_hit = &(fld_eq | alarm_in.mask);
	logic cal_q;
	logic prev_q;
	logic [31:0] run_q;

	// Calibration bit and cycles since the pin last moved
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cal_q <= 1'b0;
			prev_q <= 1'b0;
			run_q <= 32'h0;
		end else begin
			cal_q <= flags_wr ? bus.wdata[`RTCFS_BIT_CAL] : cal_q;
			prev_q <= int_out_q;
			run_q <= (int_out_q != prev_q || flags_wr) ? 32'h0 : run_q + 32'h1;
		end
	end

	sequence s_rd_flags;
		bus.rd && bus.addr == `RTCFS_ADDR_FLAGS;
	endsequence
	sequence s_quiet_rd;
		(!bus.rd)[*6] ##1 s_rd_flags;
	endsequence
	property p_wdf_set;
		$rose(wdog_zero) ##0 s_quiet_rd |=> rd_data_q[7];
	endproperty
	a_wdf_set: assert property (p_wdf_set) else $error("watchdog flag not seen");
	property p_wdf_clr;
		(!wdog_zero)[*2] ##1 (s_rd_flags and !wdog_zero) ##1 (!bus.rd && !wdog_zero)[*2]
			##1 (s_rd_flags and !wdog_zero) |=> !rd_data_q[7];
	endproperty
	a_wdf_clr: assert property (p_wdf_clr) else $error("watchdog flag kept");
	property p_af_set;
		$rose(alarm_hit) ##0 s_quiet_rd |=> rd_data_q[6];
	endproperty
	a_af_set: assert property (p_af_set) else $error("alarm flag not seen");
	property p_pf_set;
		$rose(power_fail_threshold) ##0 s_quiet_rd |=> rd_data_q[5];
	endproperty
	a_pf_set: assert property (p_pf_set) else $error("power fail flag not seen");
	property p_cal;
		cal_q |-> run_q <= CAL_HALF_CYC + 2;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration wave stalled");
	property p_freeze;
		flags_wr |=> time_ctrl_q.freeze == $past(bus.wdata[1]);
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze differs from bit");
	property p_rhold;
		flags_wr |=> time_ctrl_q.hold_update != $past(bus.wdata[0]);
	endproperty
	a_rhold: assert property (p_rhold) else $error("holding update wrong");
	property p_load;
		$rose(time_ctrl_q.load_base) |-> $past(flags_wr && !bus.wdata[1] && time_ctrl_q.freeze);
	endproperty
	a_load: assert property (p_load) else $error("base load without release");
	property p_load_one;
		time_ctrl_q.load_base |=> !time_ctrl_q.load_base;
	endproperty
	a_load_one: assert property (p_load_one) else $error("base load too long");
	property p_reset;
		$rose(resetn) |-> !time_ctrl_q.freeze && time_ctrl_q.hold_update && !int_out_q;
	endproperty
	a_reset: assert property (p_reset) else $error("control not cleared");
	// Read data stand only in the cycle after a read strobe
	property p_rd_idle;
		!bus.rd |=> rd_data_q == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule // rtcfs_top_properties

bind rtcfs_top rtcfs_top_properties #(
	.OSC_START_CYC(OSC_START_CYC),
	.CAL_HALF_CYC(CAL_HALF_CYC)
) u_rtcfs_top_properties (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.backup_resetn(backup_resetn),
	.bus(bus),
	.rd_data_q(rd_data_q),
	.alarm_in(alarm_in),
	.wdog_zero(wdog_zero),
	.time_written(time_written),
	.osc_enabled(osc_enabled),
	.power_fail_threshold(power_fail_threshold),
	.osc_running_pin(osc_running_pin),
	.int_out_q(int_out_q),
	.time_ctrl_q(time_ctrl_q)
);

/* dv/rtcfs_host.sv */
// Host model driving the register port
`timescale 1ns/1ps
module rtcfs_host
	import rtcfs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] rd_data_q,
	output rtcfs_bus_type bus
);
	initial bus = '0;

	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(posedge clk_sys);
		d = rd_data_q;
	endtask
endmodule // rtcfs_host

/* dv/rtcfs_top_bench.sv */
// Self-checking bench for the flags and control block
`timescale 1ns/1ps
module rtcfs_top_bench
	import rtcfs_pkg::*;
;
	localparam int OSC = 20;
	localparam int HALF = 4;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic backup_resetn = 1'b0;
	rtcfs_bus_type bus;
	logic [7:0] rd_data_q;
	rtcfs_alarm_type alarm_in = '{32'h0, 32'hffffffff, 4'h0};
	logic wdog_zero = 1'b0;
	logic time_written = 1'b0;
	logic osc_enabled = 1'b1;
	logic power_fail_threshold = 1'b0;
	logic osc_running_pin = 1'b0;
	logic int_out_q;
	rtcfs_time_ctrl_type time_ctrl_q;
	int n_fail = 0;
	int checked = 0;
	int tog;
	logic p;
	logic [3:0] m;
	logic [3:0] sb;
	logic [31:0] x;

	always #5 clk_sys = ~clk_sys;

	rtcfs_top #(.OSC_START_CYC(OSC), .CAL_HALF_CYC(HALF)) u_rtcfs_top (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.backup_resetn(backup_resetn),
		.bus(bus),
		.rd_data_q(rd_data_q),
		.alarm_in(alarm_in),
		.wdog_zero(wdog_zero),
		.time_written(time_written),
		.osc_enabled(osc_enabled),
		.power_fail_threshold(power_fail_threshold),
		.osc_running_pin(osc_running_pin),
		.int_out_q(int_out_q),
		.time_ctrl_q(time_ctrl_q)
	);
	rtcfs_host u_rtcfs_host (.clk_sys(clk_sys), .rd_data_q(rd_data_q), .bus(bus));

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", n_fail, checked);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic rdchk(input string s, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] g;
		u_rtcfs_host.rd(a, g);
		chk(s, e, g);
	endtask

	// Status bit of an event kind: 0 watchdog, 1 alarm, 2 power fail
	function automatic logic [3:0] ev_bit(input int k);
		return 4'h8 >> k;
	endfunction

	// Raise one event, then leave six quiet cycles before the next read
	task automatic fire(input int k);
		@(posedge clk_sys);
		case (k)
			0: wdog_zero <= 1'b1;
			1: alarm_in.alarm <= alarm_in.now;
			default: power_fail_threshold <= 1'b1;
		endcase
		repeat (2) @(posedge clk_sys);
		wdog_zero <= 1'b0;
		alarm_in.alarm <= ~alarm_in.now;
		power_fail_threshold <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Power-up pulse of three cycles on the main reset only
	task automatic pulse_reset;
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
	endtask

	// Main sequence
	initial begin
		x = $urandom(79999);
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		backup_resetn <= 1'b1;
		repeat (OSC + 8) @(posedge clk_sys);
		rdchk("status", 4'h1, 8'h01);
		rdchk("mask", 4'h2, 8'h00);
		u_rtcfs_host.wr(4'h0, 8'h10);
		rdchk("flags", 4'h0, 8'h10);
		rdchk("flags", 4'h0, 8'h10);
		u_rtcfs_host.wr(4'h0, 8'h00);
		rdchk("flags", 4'h0, 8'h00);
		osc_running_pin <= 1'b1;
		u_rtcfs_host.wr(4'hf, 8'hff);
		rdchk("unmapped", 4'hf, 8'h00);
		rdchk("mask", 4'h2, 8'h00);
		for (int i = 0; i < 12; i++) begin
			x = $urandom;
			m = 4'($urandom);
			sb = ev_bit(i % 3);
			alarm_in <= '{x, ~x, 4'($urandom % 15)};
			u_rtcfs_host.wr(4'h2, {4'h0, m});
			fire(i % 3);
			chk("int", {7'h0, |(m & sb)}, {7'h0, int_out_q});
			rdchk("flags", 4'h0, {sb, 4'h0});
			rdchk("flags", 4'h0, 8'h00);
			rdchk("status", 4'h1, {4'h0, sb});
			repeat (2) @(posedge clk_sys);
			chk("int", 8'h00, {7'h0, int_out_q});
		end
		// Write hold, base load and read hold
		u_rtcfs_host.wr(4'h0, 8'h02);
		#1 chk("freeze", 8'h01, {7'h0, time_ctrl_q.freeze});
		@(posedge clk_sys);
		time_written <= 1'b1;
		@(posedge clk_sys);
		time_written <= 1'b0;
		u_rtcfs_host.wr(4'h0, 8'h00);
		#1 chk("load", 8'h01, {7'h0, time_ctrl_q.load_base});
		u_rtcfs_host.wr(4'h0, 8'h02);
		u_rtcfs_host.wr(4'h0, 8'h00);
		#1 chk("load", 8'h00, {7'h0, time_ctrl_q.load_base});
		u_rtcfs_host.wr(4'h0, 8'h01);
		#1 chk("hold", 8'h00, {7'h0, time_ctrl_q.hold_update});
		rdchk("flags", 4'h0, 8'h01);
		u_rtcfs_host.wr(4'h0, 8'h00);
		#1 chk("hold", 8'h01, {7'h0, time_ctrl_q.hold_update});
		// Calibration wave, then normal interrupt again
		u_rtcfs_host.wr(4'h2, 8'h08);
		u_rtcfs_host.wr(4'h0, 8'h04);
		tog = 0;
		p = int_out_q;
		repeat (8 * HALF) begin
			@(posedge clk_sys);
			tog += (int_out_q !== p);
			p = int_out_q;
		end
		chk("toggles", 8'h01, {7'h0, tog >= 7 && tog <= 8});
		u_rtcfs_host.wr(4'h0, 8'h00);
		fire(0);
		chk("int", 8'h01, {7'h0, int_out_q});
		// Mid-run power-up with CAL and W set, oscillator stopped
		u_rtcfs_host.wr(4'h0, 8'h06);
		osc_running_pin <= 1'b0;
		pulse_reset();
		rdchk("flags", 4'h0, 8'h00);
		repeat (OSC + 8) @(posedge clk_sys);
		rdchk("status", 4'h1, 8'h01);
		// Fail flag survives power-up; a disabled oscillator is not flagged
		osc_enabled <= 1'b0;
		pulse_reset();
		rdchk("flags", 4'h0, 8'h10);
		repeat (OSC + 8) @(posedge clk_sys);
		rdchk("status", 4'h1, 8'h00);
		u_rtcfs_host.wr(4'h0, 8'h00);
		rdchk("flags", 4'h0, 8'h00);
		report_and_stop();
	end

	// Watchdog against a hang
	initial begin
		#50000;
		n_fail++;
		report_and_stop();
	end
endmodule // rtcfs_top_bench
